// ===== port_impedance_timer_mode_chk.sv
// checker for the port impedance and timer mode block
// sees only the top ports; bound to every instance of the block below
`timescale 1ns/1ps
`default_nettype none

module port_impedance_timer_mode_chk #(
    parameter int machine_cycle_div = port_impedance_timer_mode_pkg::machine_cycle_clocks
)(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [port_impedance_timer_mode_pkg::addr_width-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic power_down_active,
    input wire logic [2:0] strong_pullup_en,
    input wire logic [2:0] weak_pullup_transistor,
    input wire logic [2:0] output_drivers_en,
    input wire logic cascade_active,
    input wire logic watchdog_reset
);
    import port_impedance_timer_mode_pkg::*;

    // ------------
    // helper decode
    // ------------
    logic cfg_wr;
    logic [2:0] exp_drv;
    logic [2:0] exp_strong;
    logic [2:0] exp_weak;
    logic [7:0] hold_len;
    // powerdown and watchdog hold would mask the plain setting, so skip those writes
    assign cfg_wr = reg_write && reg_addr == io_mode_config_reg_addr && !watchdog_reset && !power_down_active;
    assign exp_drv = ~reg_wdata[3:1];
    assign exp_strong = exp_drv & {3{~reg_wdata[weak_pullup_select_bit]}};
    assign exp_weak = exp_drv & {3{reg_wdata[weak_pullup_select_bit]}};

    // clocks spent in the current watchdog hold
    always_ff @(posedge core_clk)
    begin
        if (!rst_b || !watchdog_reset)
            hold_len <= 8'h00;
        else
            hold_len <= hold_len + 8'h01;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // ------------
    // assertions
    // ------------
    property p_reset_pins;
        $rose(rst_b) |-> strong_pullup_en == 3'h7 && weak_pullup_transistor == 3'h0 && output_drivers_en == 3'h7;
    endproperty
    a_reset_pins: assert property (p_reset_pins) else $error("pins not at reset setting");

    property p_float_off;
        cfg_wr |-> ##2 output_drivers_en == $past(exp_drv, 2);
    endproperty
    a_float_off: assert property (p_float_off) else $error("float bits not applied");

    property p_strong;
        cfg_wr |-> ##2 strong_pullup_en == $past(exp_strong, 2);
    endproperty
    a_strong: assert property (p_strong) else $error("strong pullup wrong");

    property p_weak;
        cfg_wr |-> ##2 weak_pullup_transistor == $past(exp_weak, 2);
    endproperty
    a_weak: assert property (p_weak) else $error("weak pullup wrong");

    property p_all_off;
        (~output_drivers_en & (strong_pullup_en | weak_pullup_transistor)) == 3'h0 &&
            (strong_pullup_en & weak_pullup_transistor) == 3'h0;
    endproperty
    a_all_off: assert property (p_all_off) else $error("transistor on in floating port");

    property p_cascade;
        cfg_wr |-> ##2 cascade_active == $past(reg_wdata[cascade_enable_bit], 2);
    endproperty
    a_cascade: assert property (p_cascade) else $error("cascade flag not following");

    property p_hold_len;
        $fell(watchdog_reset) |-> hold_len == watchdog_reset_cycles * machine_cycle_div;
    endproperty
    a_hold_len: assert property (p_hold_len) else $error("watchdog hold length wrong");

    property p_hold_clears;
        watchdog_reset && $past(watchdog_reset) |-> strong_pullup_en == 3'h7 && output_drivers_en == 3'h7;
    endproperty
    a_hold_clears: assert property (p_hold_clears) else $error("ports not reset in hold");

    property p_rdata_idle;
        !$past(reg_read) |-> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");
endmodule

bind port_impedance_timer_mode_ctrl port_impedance_timer_mode_chk #(.machine_cycle_div(machine_cycle_div)) chk_inst (
    .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .power_down_active(power_down_active),
    .strong_pullup_en(strong_pullup_en),
    .weak_pullup_transistor(weak_pullup_transistor), .output_drivers_en(output_drivers_en),
    .cascade_active(cascade_active), .watchdog_reset(watchdog_reset));
`default_nettype wire

// ===== port_impedance_timer_mode_ctrl.sv
// i/o impedance select, powerdown float and timer 0/1 cascade and watchdog control
// assumes inputs synchronous to core_clk; powerdown entry/exit logic lives outside
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module port_impedance_timer_mode_ctrl #(
    parameter int machine_cycle_div = port_impedance_timer_mode_pkg::machine_cycle_clocks
)(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [port_impedance_timer_mode_pkg::addr_width-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic power_down_active,
    input wire logic wake_request,
    input wire logic serial_error_event,
    input wire logic timer0_event_pin,
    input wire logic timer1_event_pin,
    input wire logic timer0_gate_pin,
    input wire logic timer1_gate_pin,
    output logic [2:0] strong_pullup_en,
    output logic [2:0] weak_pullup_transistor,
    output logic [2:0] output_drivers_en,
    output logic timer1_overflow_flag,
    output logic cascade_active,
    output logic watchdog_reset
);
    import port_impedance_timer_mode_pkg::*;

    // ------------
    // declarations
    // ------------
    localparam logic [3:0] wd_last = 4'(watchdog_reset_cycles - 1);
    localparam logic [7:0] div_last = 8'(machine_cycle_div - 1);

    logic [7:0] io_mode_config_reg;
    logic [7:0] timer_mode_reg;
    logic [1:0] timer_run;
    logic timer0_overflow_flag;
    logic [7:0] tl0, th0, tl1, th1;
    logic [7:0] cycle_count;
    logic tick;
    logic pin0_last, pin1_last;
    logic pd_last;
    logic pd_float;
    logic soft_rst;
    watchdog_state_e wd_state;
    logic [3:0] wd_count;
    logic step0, step1;
    logic [16:0] res0, res1;
    logic ovf0_evt, ovf1_evt;
    logic wr_cfg, wr_timer_mode_reg, wr_ctrl;
    logic [2:0] float_sel;
    logic weak_sel;
    logic [7:0] next_rdata;

    assign wr_cfg = reg_write && reg_addr == io_mode_config_reg_addr;
    assign wr_timer_mode_reg = reg_write && reg_addr == timer_mode_reg_addr;
    assign wr_ctrl = reg_write && reg_addr == timer_ctrl_reg_addr;
    assign float_sel = io_mode_config_reg[port1_float_select_bit +: 3];
    assign weak_sel = io_mode_config_reg[weak_pullup_select_bit];

    // ------------
    // timer step function: {overflow, high, low}
    // ------------
    // split mode is kept as a plain 8-bit counter on the low byte
    function automatic logic [16:0] timer_step(input logic [7:0] lo, input logic [7:0] hi,
                                               input logic [1:0] mode, input logic wide);
        logic [12:0] c13;
        logic [16:0] c16;
        logic [8:0] c8;
        c13 = {hi, lo[4:0]} + 13'h0001;
        c16 = {1'b0, hi, lo} + 17'h00001;
        c8 = {1'b0, lo} + 9'h001;
        if (wide || mode == mode_16bit)
            timer_step = c16;
        else if (mode == mode_13bit)
            timer_step = {({hi, lo[4:0]} == 13'h1FFF), c13[12:5], lo[7:5], c13[4:0]};
        else if (mode == mode_8bit_reload)
            timer_step = {c8[8], hi, (c8[8] ? hi : c8[7:0])};
        else
            timer_step = {c8[8], hi, c8[7:0]};
    endfunction

    // ------------
    // machine cycle tick
    // ------------
    // free running so watchdog timing never stalls on its own reset
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            cycle_count <= 8'h00;
        else if (cycle_count == div_last)
            cycle_count <= 8'h00;
        else
            cycle_count <= cycle_count + 8'h01;
    end
    assign tick = (cycle_count == div_last);

    // ------------
    // watchdog internal reset sequencer
    // ------------
    // overflow in watchdog mode: wait for next machine cycle, then hold
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            wd_state <= wd_idle;
            wd_count <= 4'h0;
        end
        else
        begin
            case (wd_state)
                wd_idle:
                    if (ovf1_evt && io_mode_config_reg[watchdog_mode_enable_bit])
                        wd_state <= wd_wait;
                wd_wait:
                    if (tick)
                    begin
                        wd_state <= wd_hold;
                        wd_count <= 4'h0;
                    end
                wd_hold:
                    if (tick)
                    begin
                        if (wd_count == wd_last)
                            wd_state <= wd_idle;
                        else
                            wd_count <= wd_count + 4'h1;
                    end
                default:
                    wd_state <= wd_idle;
            endcase
        end
    end
    // watchdog reset acts like a hardware reset on every register below except watchdog_reset and reg_rdata
    assign soft_rst = !rst_b || wd_state == wd_hold;

    // ------------
    // configuration register
    // ------------
    // no write protection on the watchdog bit; software must use bit ops
    always_ff @(posedge core_clk)
    begin
        if (soft_rst)
            io_mode_config_reg <= io_mode_config_reset;
        else
        begin
            if (wr_cfg)
                io_mode_config_reg <= reg_wdata;
            if (serial_error_event)
                io_mode_config_reg[serial_error_flag_bit] <= 1'b1; // set beats clear
        end
    end

    // timer mode register and run bits
    always_ff @(posedge core_clk)
    begin
        if (soft_rst)
        begin
            timer_mode_reg <= timer_mode_reset;
            timer_run <= 2'b00;
        end
        else
        begin
            if (wr_timer_mode_reg)
                timer_mode_reg <= reg_wdata;
            if (wr_ctrl)
                timer_run <= reg_wdata[run1_bit:run0_bit];
        end
    end

    // ------------
    // count sources
    // ------------
    // external pin sampled once per machine cycle, counts on 1 to 0
    always_ff @(posedge core_clk)
    begin
        if (soft_rst)
        begin
            pin0_last <= 1'b0;
            pin1_last <= 1'b0;
        end
        else if (tick)
        begin
            pin0_last <= timer0_event_pin;
            pin1_last <= timer1_event_pin;
        end
    end

    // cascade runs on its own enable; timer run bits stay for plain modes
    always_comb
    begin
        step0 = 1'b0;
        if (tick)
        begin
            if (timer_mode_reg[2])
                step0 = pin0_last && !timer0_event_pin;
            else
                step0 = 1'b1;
            if (!io_mode_config_reg[cascade_enable_bit])
                step0 = step0 && timer_run[0] && (!timer_mode_reg[3] || timer0_gate_pin);
        end
    end

    always_comb
    begin
        res0 = timer_step(tl0, th0, timer_mode_reg[1:0], io_mode_config_reg[cascade_enable_bit]);
        if (io_mode_config_reg[cascade_enable_bit])
            step1 = step0 && res0[16];
        else if (tick && timer_run[1] && (!timer_mode_reg[7] || timer1_gate_pin))
            step1 = timer_mode_reg[6] ? (pin1_last && !timer1_event_pin) : 1'b1;
        else
            step1 = 1'b0;
        // in cascade the high half always counts full 16 bits
        res1 = timer_step(tl1, th1, timer_mode_reg[5:4], io_mode_config_reg[cascade_enable_bit]);
    end
    assign ovf0_evt = step0 && res0[16] && !io_mode_config_reg[cascade_enable_bit];
    assign ovf1_evt = step1 && res1[16]; // 32-bit overflow in cascade

    // ------------
    // timer counters
    // ------------
    // a software write in the same cycle wins over the count
    always_ff @(posedge core_clk)
    begin
        if (soft_rst)
        begin
            tl0 <= timer_byte_reset;
            th0 <= timer_byte_reset;
        end
        else
        begin
            if (step0)
            begin
                tl0 <= res0[7:0];
                th0 <= res0[15:8];
            end
            if (reg_write && reg_addr == timer0_low_addr)
                tl0 <= reg_wdata;
            if (reg_write && reg_addr == timer0_high_addr)
                th0 <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (soft_rst)
        begin
            tl1 <= timer_byte_reset;
            th1 <= timer_byte_reset;
        end
        else
        begin
            if (step1)
            begin
                tl1 <= res1[7:0];
                th1 <= res1[15:8];
            end
            if (reg_write && reg_addr == timer1_low_addr)
                tl1 <= reg_wdata;
            if (reg_write && reg_addr == timer1_high_addr)
                th1 <= reg_wdata;
        end
    end

    // overflow flags: writing 0 clears, a same-cycle overflow still sets
    always_ff @(posedge core_clk)
    begin
        if (soft_rst)
        begin
            timer0_overflow_flag <= 1'b0;
            timer1_overflow_flag <= 1'b0;
        end
        else
        begin
            if (wr_ctrl && !reg_wdata[overflow0_bit])
                timer0_overflow_flag <= 1'b0;
            if (wr_ctrl && !reg_wdata[overflow1_bit])
                timer1_overflow_flag <= 1'b0;
            if (ovf0_evt)
                timer0_overflow_flag <= 1'b1;
            if (ovf1_evt)
                timer1_overflow_flag <= 1'b1;
        end
    end

    // ------------
    // powerdown float
    // ------------
    // float bit is sampled at entry; wake request ends it before osc restart
    always_ff @(posedge core_clk)
    begin
        if (soft_rst)
        begin
            pd_last <= 1'b0;
            pd_float <= 1'b0;
        end
        else
        begin
            pd_last <= power_down_active;
            if (power_down_active && !pd_last && io_mode_config_reg[float_ports_in_powerdown_bit])
                pd_float <= 1'b1;
            if (wake_request || !power_down_active)
                pd_float <= 1'b0;
        end
    end

    // ------------
    // port transistor enables
    // ------------
    // config bits are untouched in powerdown, so release restores them
    always_ff @(posedge core_clk)
    begin
        if (soft_rst)
        begin
            strong_pullup_en <= 3'b111;
            weak_pullup_transistor <= 3'b000;
            output_drivers_en <= 3'b111;
        end
        else
        begin
            for (int i = 0; i < 3; i++)
            begin
                // float or powerdown float: everything off
                output_drivers_en[i] <= !float_sel[i] && !pd_float;
                strong_pullup_en[i] <= !float_sel[i] && !weak_sel && !pd_float;
                weak_pullup_transistor[i] <= !float_sel[i] && weak_sel && !pd_float;
            end
        end
    end

    // ------------
    // status outputs
    // ------------
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            cascade_active <= 1'b0;
            watchdog_reset <= 1'b0;
        end
        else
        begin
            cascade_active <= soft_rst ? 1'b0 : io_mode_config_reg[cascade_enable_bit];
            watchdog_reset <= (wd_state == wd_wait && tick) ||
                              (wd_state == wd_hold && !(tick && wd_count == wd_last));
        end
    end

    // ------------
    // register read port
    // ------------
    // unmapped offsets and idle cycles read zero
    always_comb
    begin
        next_rdata = 8'h00;
        if (reg_read)
        begin
            case (reg_addr)
                io_mode_config_reg_addr: next_rdata = io_mode_config_reg;
                timer_mode_reg_addr: next_rdata = timer_mode_reg;
                timer_ctrl_reg_addr: next_rdata = {4'h0, timer1_overflow_flag, timer0_overflow_flag, timer_run};
                timer0_low_addr: next_rdata = tl0;
                timer0_high_addr: next_rdata = th0;
                timer1_low_addr: next_rdata = tl1;
                timer1_high_addr: next_rdata = th1;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= next_rdata;
    end

endmodule

`default_nettype wire

// ===== port_impedance_timer_mode_ctrl_tb.sv
// self-checking bench for the port impedance and timer mode block
// uses a short machine cycle so timer and watchdog runs stay brief
`timescale 1ns/1ps
`default_nettype none

module port_impedance_timer_mode_ctrl_tb;
    import port_impedance_timer_mode_pkg::*;
    localparam int div = 2;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic power_down_active = 1'b0;
    logic wake_request = 1'b0;
    logic serial_error_event = 1'b0;
    logic [7:0] reg_rdata;
    logic timer0_event_pin;
    logic [2:0] strong_pullup_en;
    logic [2:0] weak_pullup_transistor;
    logic [2:0] output_drivers_en;
    logic timer1_overflow_flag;
    logic cascade_active;
    logic watchdog_reset;
    int error_cnt = 0;
    int compares = 0;
    int n;

    // ------------
    // clock, design and load
    // ------------
    initial
    begin
        forever #2.5 core_clk = ~core_clk;
    end

    port_impedance_timer_mode_ctrl #(.machine_cycle_div(div)) port_impedance_timer_mode_ctrl_inst (
        .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .power_down_active(power_down_active),
        .wake_request(wake_request), .serial_error_event(serial_error_event),
        .timer0_event_pin(timer0_event_pin), .timer1_event_pin(1'b1), .timer0_gate_pin(1'b0),
        .timer1_gate_pin(1'b0), .strong_pullup_en(strong_pullup_en), .weak_pullup_transistor(weak_pullup_transistor),
        .output_drivers_en(output_drivers_en), .timer1_overflow_flag(timer1_overflow_flag),
        .cascade_active(cascade_active), .watchdog_reset(watchdog_reset));

    port_load_model port_load_model_inst (
        .core_clk(core_clk), .strong_pullup_en(strong_pullup_en), .weak_pullup_transistor(weak_pullup_transistor),
        .output_drivers_en(output_drivers_en), .event_pin(timer0_event_pin));

    // ------------
    // access and compare tasks
    // ------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1;
        check({8'h00, reg_rdata}, {8'h00, exp});
    endtask

    // enables need the config edge plus the output flop edge to land
    task automatic pins(input logic [2:0] s, input logic [2:0] w, input logic [2:0] d);
        repeat (3) @(posedge core_clk);
        #1;
        check({7'h00, strong_pullup_en, weak_pullup_transistor, output_drivers_en}, {7'h00, s, w, d});
    endtask

    task automatic load32(input logic [31:0] v);
        for (int b = 0; b < 4; b++)
            wr(timer0_low_addr + 4'(b), v[8*b +: 8]);
    endtask

    task automatic wait_wd(input logic lvl);
        int i;
        for (i = 0; i < 400 && watchdog_reset !== lvl; i++)
        begin
            @(posedge core_clk);
            #1;
        end
        check({15'h0000, watchdog_reset}, {15'h0000, lvl});
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ------------
    // tests
    // ------------
    initial
    begin
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        pins(3'h7, 3'h0, 3'h7);
        for (n = 0; n < 7; n++)
            rd(4'(n), 8'h00);
        $display("reset test done");
        // every float and weak select combination, back to back with readback
        for (n = 0; n < 16; n++)
        begin
            wr(io_mode_config_reg_addr, 8'(n << 1));
            pins(~3'(n) & {3{~n[3]}}, ~3'(n) & {3{n[3]}}, ~3'(n));
            rd(io_mode_config_reg_addr, 8'(n << 1));
        end
        wr(4'h9, 8'hFF);
        rd(4'h9, 8'h00);
        rd(io_mode_config_reg_addr, 8'h1E);
        @(posedge core_clk);
        serial_error_event <= 1'b1;
        @(posedge core_clk);
        serial_error_event <= 1'b0;
        rd(io_mode_config_reg_addr, 8'h3E);
        $display("impedance test done");
        // powerdown float, wake restore while still down, then without the float bit
        wr(io_mode_config_reg_addr, 8'h13);
        pins(3'h0, 3'h6, 3'h6);
        @(posedge core_clk);
        power_down_active <= 1'b1;
        pins(3'h0, 3'h0, 3'h0);
        @(posedge core_clk);
        wake_request <= 1'b1;
        @(posedge core_clk);
        wake_request <= 1'b0;
        pins(3'h0, 3'h6, 3'h6);
        @(posedge core_clk);
        power_down_active <= 1'b0;
        wr(io_mode_config_reg_addr, 8'h10);
        @(posedge core_clk);
        power_down_active <= 1'b1;
        pins(3'h0, 3'h7, 3'h7);
        @(posedge core_clk);
        power_down_active <= 1'b0;
        $display("powerdown test done");
        // low half overflow carries into the high half only
        wr(timer_mode_reg_addr, 8'h00);
        load32(32'h0012FFFF);
        wr(io_mode_config_reg_addr, 8'h40);
        pins(3'h7, 3'h0, 3'h7);
        check({15'h0000, cascade_active}, 16'h0001);
        repeat (4 * div) @(posedge core_clk);
        wr(io_mode_config_reg_addr, 8'h00);
        rd(timer1_low_addr, 8'h13);
        rd(timer1_high_addr, 8'h00);
        rd(timer_ctrl_reg_addr, 8'h00);
        // full 32-bit overflow raises only the high flag
        load32(32'hFFFFFFFC);
        wr(io_mode_config_reg_addr, 8'h40);
        repeat (10 * div) @(posedge core_clk);
        wr(io_mode_config_reg_addr, 8'h00);
        rd(timer_ctrl_reg_addr, 8'h08);
        check({15'h0000, timer1_overflow_flag}, 16'h0001);
        wr(timer_ctrl_reg_addr, 8'h00);
        rd(timer_ctrl_reg_addr, 8'h00);
        // external events counted on falling samples
        wr(timer_mode_reg_addr, 8'h04);
        load32(32'h00000000);
        wr(io_mode_config_reg_addr, 8'h40);
        port_load_model_inst.send_events(3, 3 * div);
        wr(io_mode_config_reg_addr, 8'h00);
        rd(timer0_low_addr, 8'h03);
        rd(timer0_high_addr, 8'h00);
        $display("cascade test done");
        // watchdog on the cascaded timer; a write during the hold is lost
        wr(timer_mode_reg_addr, 8'h00);
        load32(32'hFFFFFFF0);
        wr(io_mode_config_reg_addr, 8'h40);
        rd(io_mode_config_reg_addr, 8'h40);
        wr(io_mode_config_reg_addr, 8'hC0);
        wait_wd(1'b1);
        wr(io_mode_config_reg_addr, 8'h02);
        wait_wd(1'b0);
        rd(io_mode_config_reg_addr, 8'h00);
        rd(timer_mode_reg_addr, 8'h00);
        rd(timer1_high_addr, 8'h00);
        pins(3'h7, 3'h0, 3'h7);
        check(16'(port_load_model_inst.fault_cnt), 16'h0000);
        $display("watchdog test done");
        results();
    end

    // run takes a few hundred clocks; far beyond that means a hang
    initial
    begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        results();
    end
endmodule
`default_nettype wire

// ===== port_impedance_timer_mode_pkg.sv
// constants, register map and field layout for the port impedance and timer mode block
// assumes a single 200 MHz core clock and a plain strobe-style register port
//
// Functional notes
// - set float bit turns off that port's transistors
// - float and weak select low give strong pullup
// - reset leaves all ports at strong pullup
// - weak select alone enables only weak pullup
// - three-state turns off every output transistor
// - powerdown float bit floats all ports in powerdown
// - powerdown exit restores previous port impedance
// - restore happens at wake request, not oscillator
// - cascade with timer select gives 32-bit timer
// - cascade with counter select counts external events
// - watchdog from timer1 overflow, width follows timer1 mode (32-bit in cascade)
// - timer0 low half, overflow increments timer1
// - watchdog overflow resets at the next machine cycle, held for five

package port_impedance_timer_mode_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam int addr_width = 4;
    localparam logic [3:0] io_mode_config_reg_addr = 4'h0;
    localparam logic [3:0] timer_mode_reg_addr = 4'h1;
    localparam logic [3:0] timer_ctrl_reg_addr = 4'h2;
    localparam logic [3:0] timer0_low_addr = 4'h3;
    localparam logic [3:0] timer0_high_addr = 4'h4;
    localparam logic [3:0] timer1_low_addr = 4'h5;
    localparam logic [3:0] timer1_high_addr = 4'h6;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int float_ports_in_powerdown_bit = 0;
    localparam int port1_float_select_bit = 1;
    localparam int weak_pullup_select_bit = 4;
    localparam int serial_error_flag_bit = 5;
    localparam int cascade_enable_bit = 6;
    localparam int watchdog_mode_enable_bit = 7;
    localparam int run0_bit = 0;
    localparam int run1_bit = 1;
    localparam int overflow0_bit = 2;
    localparam int overflow1_bit = 3;
    localparam logic [7:0] io_mode_config_reset = 8'h00;
    localparam logic [7:0] timer_mode_reset = 8'h00;
    localparam logic [7:0] timer_byte_reset = 8'h00;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int machine_cycle_clocks = 12;
    localparam int watchdog_reset_cycles = 5;
    localparam int clock_period_ps = 5000;

    // timer mode field values
    localparam logic [1:0] mode_13bit = 2'h0;
    localparam logic [1:0] mode_16bit = 2'h1;
    localparam logic [1:0] mode_8bit_reload = 2'h2;
    localparam logic [1:0] mode_split = 2'h3;

    typedef enum logic [1:0] {wd_idle, wd_wait, wd_hold} watchdog_state_e;

endpackage

// ===== port_load_model.sv
// load model for the three configurable ports and the timer 0 event input
// sees the block's transistor enables; the bench sends events through its task
`timescale 1ns/1ps
`default_nettype none

module port_load_model (
    input wire logic core_clk,
    input wire logic [2:0] strong_pullup_en,
    input wire logic [2:0] weak_pullup_transistor,
    input wire logic [2:0] output_drivers_en,
    output logic event_pin
);
    int fault_cnt = 0;
    // pin has an internal pullup, so it idles high
    initial event_pin = 1'b1;

    // a pullup on a floated port, or both pullups at once, would fight the load
    always @(posedge core_clk)
    begin
        for (int p = 0; p < 3; p++)
        begin
            if ((strong_pullup_en[p] && weak_pullup_transistor[p]) ||
                (!output_drivers_en[p] && (strong_pullup_en[p] || weak_pullup_transistor[p])))
                fault_cnt++;
        end
    end

    // low then high for half clocks each; counted once per falling sample
    task automatic send_events(input int count, input int half);
        repeat (count)
        begin
            repeat (half) @(posedge core_clk);
            event_pin <= 1'b0;
            repeat (half) @(posedge core_clk);
            event_pin <= 1'b1;
        end
        repeat (half) @(posedge core_clk);
    endtask
endmodule
`default_nettype wire
